//--- pkg/wdrl_defines.svh
/*
 * Constants of the watchdog refresh and configuration-lock block.
 * Assumes byte-wide register writes arriving on the bus clock.
 */
`ifndef WDRL_DEFINES_SVH
`define WDRL_DEFINES_SVH

// Refresh words, high byte written first
`define WDRL_KEY1_HI 8'ha6
`define WDRL_KEY1_LO 8'h02
`define WDRL_KEY2_HI 8'hb4
`define WDRL_KEY2_LO 8'h80

// Longest span of the four refresh byte writes, in bus clocks
`define WDRL_REFRESH_SPAN 16
// Fewest clocks that can carry four byte writes
`define WDRL_REFRESH_MIN_SPAN 4
// Span counter width
`define WDRL_SPAN_W 5

// Control bit positions
`define WDRL_CTL_ONE_UPDATE_BIT 5
`define WDRL_CTL_TWO_WIN_BIT 7

// Reset-default settings used until a configuration is applied
`define WDRL_CTL_ONE_RESET 8'ha0
`define WDRL_CTL_TWO_RESET 8'h00
`define WDRL_TIMEOUT_RESET 16'hffff
`define WDRL_WINDOW_RESET 16'h0000

`endif

//--- pkg/wdrl_pkg.sv
/*
 * Types of the watchdog refresh and configuration-lock block.
 * Assumes the defines header sits on the include path.
 */
`default_nettype none

package wdrl_pkg;

    // Which watchdog byte register a write targets
    typedef enum logic [2:0] {
        WDRL_T_CTL_ONE,
        WDRL_T_CTL_TWO,
        WDRL_T_CNT_HI,
        WDRL_T_CNT_LO,
        WDRL_T_TOV_HI,
        WDRL_T_TOV_LO,
        WDRL_T_WIN_HI,
        WDRL_T_WIN_LO
    } wdrl_target_e;

    // One byte write from the register decoder
    typedef struct packed {
        logic valid;
        wdrl_target_e target;
        logic [7:0] data;
    } wdrl_wr_s;

    // Settings in force
    typedef struct packed {
        logic [7:0] control_status_one;
        logic [7:0] control_status_two;
        logic [15:0] timeout;
        logic [15:0] window;
    } wdrl_cfg_s;

    // Refresh sequencer states
    typedef enum logic [1:0] {
        WDRL_S_IDLE,
        WDRL_S_GOT1,
        WDRL_S_GOT2,
        WDRL_S_GOT3
    } wdrl_seq_e;

    // True when a write is valid and aims at the given register
    function automatic logic wdrl_hit(input wdrl_wr_s wr, input wdrl_target_e t);
        wdrl_hit = wr.valid && (wr.target == t);
    endfunction : wdrl_hit

endpackage : wdrl_pkg

`default_nettype wire

//--- hdl/wdrl_refresh_seq.sv
/*
 * Refresh sequencer: checks four byte writes to the refresh counter.
 * Assumes writes come from logic on clk_sys, at most one per clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "wdrl_defines.svh"

module wdrl_refresh_seq
    import wdrl_pkg::*;
#(
    parameter int SPAN = `WDRL_REFRESH_SPAN
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    input wire wdrl_wr_s wr,
    output logic refresh_ok,
    output logic refresh_bad,
    output logic busy
);

    localparam logic [`WDRL_SPAN_W-1:0] LAST = (`WDRL_SPAN_W)'(SPAN - 1);

    // Budget must hold four writes and fit the span counter
    if (SPAN < `WDRL_REFRESH_MIN_SPAN || SPAN > (1 << `WDRL_SPAN_W)) begin : g_bad_span
        $error("wdrl_refresh_seq: SPAN out of range");
    end

    wdrl_seq_e state; // Progress through the four bytes
    wdrl_seq_e next_state;
    logic [`WDRL_SPAN_W-1:0] span; // Clocks since the first byte
    logic next_ok;
    logic next_bad;

    // Byte decode
    wire logic w_hi = wdrl_hit(wr, WDRL_T_CNT_HI);
    wire logic w_lo = wdrl_hit(wr, WDRL_T_CNT_LO);
    wire logic any_cnt = w_hi || w_lo;
    wire logic k1h = w_hi && (wr.data == `WDRL_KEY1_HI);
    wire logic k1l = w_lo && (wr.data == `WDRL_KEY1_LO);
    wire logic k2h = w_hi && (wr.data == `WDRL_KEY2_HI);
    wire logic k2l = w_lo && (wr.data == `WDRL_KEY2_LO);
    // Budget spent: this is the last clock the fourth byte may land in
    wire logic at_last = (span == LAST);

    // Next-state decode
    always_comb begin
        next_state = state;
        next_ok = 1'b0;
        next_bad = 1'b0;
        case (state)
            WDRL_S_IDLE: begin
                if (k1h) begin
                    next_state = WDRL_S_GOT1;
                end else if (any_cnt) begin
                    next_bad = 1'b1;
                end
            end
            WDRL_S_GOT1: begin
                if (k1l) next_state = WDRL_S_GOT2;
                else if (any_cnt) next_bad = 1'b1;
            end
            WDRL_S_GOT2: begin
                if (k2h) next_state = WDRL_S_GOT3;
                else if (any_cnt) next_bad = 1'b1;
            end
            WDRL_S_GOT3: begin
                if (k2l) begin
                    next_state = WDRL_S_IDLE;
                    next_ok = 1'b1;
                end else if (any_cnt) begin
                    next_bad = 1'b1;
                end
            end
            default: begin
                next_state = WDRL_S_IDLE;
            end
        endcase
        // Out-of-order byte aborts the sequence
        if (next_bad) begin
            next_state = WDRL_S_IDLE;
        end
        // Too slow: the sequence is dropped unless it just completed
        if ((state != WDRL_S_IDLE) && at_last && !next_ok && !next_bad) begin
            next_state = WDRL_S_IDLE;
            next_bad = 1'b1;
        end
    end

    // State, span counter and result pulses
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            state <= WDRL_S_IDLE;
            span <= '0;
            refresh_ok <= 1'b0;
            refresh_bad <= 1'b0;
            busy <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            // Counts from the first byte's edge, so span is clocks since it
            span <= (next_state == WDRL_S_IDLE) ? '0 : span + 1'b1;
            refresh_ok <= next_ok;
            refresh_bad <= next_bad;
            busy <= (next_state != WDRL_S_IDLE);
        end
    end

endmodule : wdrl_refresh_seq

`default_nettype wire

//--- hdl/wdrl_top.sv
/*
 * Watchdog refresh and configuration-lock logic.
 * Holds write-once configuration bytes, applies them once complete,
 * and checks the two-word refresh sequence through a sequencer.
 * Assumes a register decoder on clk_sys hands in one byte write per
 * clock as a wdrl_wr_s; the counting core sits outside and takes
 * cfg and refresh from here.
 */
`timescale 1ns/1ps
`default_nettype none
`include "wdrl_defines.svh"

// Summary of operation
// - Refresh is 0xA602 then 0xB480, in order
// - Four refresh bytes within 16 bus clocks
// - Config bytes accept one write after reset
// - Update bit written zero locks the configuration
// - New setup applies after all registers written
// - Window pair not needed when window mode off
module wdrl_top
    import wdrl_pkg::*;
#(
    parameter int REFRESH_SPAN = `WDRL_REFRESH_SPAN
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    input wire wdrl_wr_s wr,
    output wdrl_cfg_s cfg,
    output logic cfg_applied,
    output logic cfg_locked,
    output logic refresh,
    output logic refresh_invalid,
    output logic refresh_busy,
    output logic wr_refused
);

    // The sequencer must be able to fit four writes into its budget
    if (REFRESH_SPAN < `WDRL_REFRESH_MIN_SPAN ||
        REFRESH_SPAN > (1 << `WDRL_SPAN_W)) begin : g_bad_span
        $error("wdrl_top: REFRESH_SPAN out of range");
    end

    // Shadow copies of written configuration bytes
    logic [7:0] sh_ctl_one;
    logic [7:0] sh_ctl_two;
    logic [7:0] sh_tov_hi;
    logic [7:0] sh_tov_lo;
    logic [7:0] sh_win_hi;
    logic [7:0] sh_win_lo;

    // Written-once flags, one per configuration byte
    logic wn_ctl_one;
    logic wn_ctl_two;
    logic wn_tov_hi;
    logic wn_tov_lo;
    logic wn_win_hi;
    logic wn_win_lo;

    // Raw sequencer results, registered inside the sequencer
    logic seq_ok;
    logic seq_bad;
    logic seq_busy;

    // Per-register write strobes
    wire logic hit_ctl_one = wdrl_hit(wr, WDRL_T_CTL_ONE);
    wire logic hit_ctl_two = wdrl_hit(wr, WDRL_T_CTL_TWO);
    wire logic hit_tov_hi = wdrl_hit(wr, WDRL_T_TOV_HI);
    wire logic hit_tov_lo = wdrl_hit(wr, WDRL_T_TOV_LO);
    wire logic hit_win_hi = wdrl_hit(wr, WDRL_T_WIN_HI);
    wire logic hit_win_lo = wdrl_hit(wr, WDRL_T_WIN_LO);

    // Once locked, no configuration byte may change at all
    wire logic cfg_open = !cfg_locked;

    // A byte is taken only on its first write since reset
    wire logic take_ctl_one = hit_ctl_one && !wn_ctl_one && cfg_open;
    wire logic take_ctl_two = hit_ctl_two && !wn_ctl_two && cfg_open;
    wire logic take_tov_hi = hit_tov_hi && !wn_tov_hi && cfg_open;
    wire logic take_tov_lo = hit_tov_lo && !wn_tov_lo && cfg_open;
    wire logic take_win_hi = hit_win_hi && !wn_win_hi && cfg_open;
    wire logic take_win_lo = hit_win_lo && !wn_win_lo && cfg_open;

    // Any config write that was dropped
    wire logic refused = (hit_ctl_one && !take_ctl_one) || (hit_ctl_two && !take_ctl_two) ||
                         (hit_tov_hi && !take_tov_hi) ||
                         (hit_tov_lo && !take_tov_lo) ||
                         (hit_win_hi && !take_win_hi) ||
                         (hit_win_lo && !take_win_lo);

    // Flags and values as they stand after this cycle's write
    wire logic nw_ctl_one = wn_ctl_one || take_ctl_one;
    wire logic nw_ctl_two = wn_ctl_two || take_ctl_two;
    wire logic nw_tov = (wn_tov_hi || take_tov_hi) && (wn_tov_lo || take_tov_lo);
    wire logic nw_win = (wn_win_hi || take_win_hi) && (wn_win_lo || take_win_lo);
    wire logic [7:0] nv_ctl_one = take_ctl_one ? wr.data : sh_ctl_one;
    wire logic [7:0] nv_ctl_two = take_ctl_two ? wr.data : sh_ctl_two;
    wire logic [7:0] nv_tov_hi = take_tov_hi ? wr.data : sh_tov_hi;
    wire logic [7:0] nv_tov_lo = take_tov_lo ? wr.data : sh_tov_lo;
    wire logic [7:0] nv_win_hi = take_win_hi ? wr.data : sh_win_hi;
    wire logic [7:0] nv_win_lo = take_win_lo ? wr.data : sh_win_lo;

    // Window pair counts only when the written setup selects window mode
    wire logic win_mode = nv_ctl_two[`WDRL_CTL_TWO_WIN_BIT];
    wire logic win_done = nw_win || !win_mode;

    // Everything except the refresh pair, and the window pair outside window mode, has been written
    wire logic all_done = nw_ctl_one && nw_ctl_two && nw_tov && win_done;
    wire logic apply_now = all_done && !cfg_applied;

    // Setup that becomes active at the apply edge
    wdrl_cfg_s next_cfg;
    assign next_cfg.control_status_one = nv_ctl_one;
    assign next_cfg.control_status_two = nv_ctl_two;
    assign next_cfg.timeout = {nv_tov_hi, nv_tov_lo};
    // Unless the window pair has been written the window stays at its default
    assign next_cfg.window = nw_win ? {nv_win_hi, nv_win_lo} : `WDRL_WINDOW_RESET;

    // Update bit cleared in the applied setup locks everything
    wire logic next_locked = apply_now && !nv_ctl_one[`WDRL_CTL_ONE_UPDATE_BIT];

    // Written-once flags; never clear except by reset
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            wn_ctl_one <= 1'b0;
            wn_ctl_two <= 1'b0;
            wn_tov_hi <= 1'b0;
            wn_tov_lo <= 1'b0;
            wn_win_hi <= 1'b0;
            wn_win_lo <= 1'b0;
        end else if (ce) begin
            wn_ctl_one <= nw_ctl_one;
            wn_ctl_two <= nw_ctl_two;
            wn_tov_hi <= wn_tov_hi || take_tov_hi;
            wn_tov_lo <= wn_tov_lo || take_tov_lo;
            wn_win_hi <= wn_win_hi || take_win_hi;
            wn_win_lo <= wn_win_lo || take_win_lo;
        end
    end

    // Shadow bytes; reset values keep unwritten fields sane
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            sh_ctl_one <= `WDRL_CTL_ONE_RESET;
            sh_ctl_two <= `WDRL_CTL_TWO_RESET;
            // Byte pairs loaded whole, so no width is cut
            {sh_tov_hi, sh_tov_lo} <= `WDRL_TIMEOUT_RESET;
            {sh_win_hi, sh_win_lo} <= `WDRL_WINDOW_RESET;
        end else if (ce) begin
            sh_ctl_one <= nv_ctl_one;
            sh_ctl_two <= nv_ctl_two;
            sh_tov_hi <= nv_tov_hi;
            sh_tov_lo <= nv_tov_lo;
            sh_win_hi <= nv_win_hi;
            sh_win_lo <= nv_win_lo;
        end
    end

    // Active setup: defaults until the single apply, then frozen
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            cfg.control_status_one <= `WDRL_CTL_ONE_RESET;
            cfg.control_status_two <= `WDRL_CTL_TWO_RESET;
            cfg.timeout <= `WDRL_TIMEOUT_RESET;
            cfg.window <= `WDRL_WINDOW_RESET;
            cfg_applied <= 1'b0;
            cfg_locked <= 1'b0;
        end else if (ce) begin
            if (apply_now) begin
                cfg <= next_cfg;
                cfg_applied <= 1'b1;
            end
            // Lock is sticky until reset
            cfg_locked <= cfg_locked || next_locked;
        end
    end

    // Refresh sequence checker
    wdrl_refresh_seq #(
        .SPAN(REFRESH_SPAN)
    ) u_seq (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .ce(ce),
        .wr(wr),
        .refresh_ok(seq_ok),
        .refresh_bad(seq_bad),
        .busy(seq_busy)
    );

    // Result outputs re-timed; sequencer results pass a second flop stage, wr_refused only this one
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            refresh <= 1'b0;
            refresh_invalid <= 1'b0;
            refresh_busy <= 1'b0;
            wr_refused <= 1'b0;
        end else if (ce) begin
            refresh <= seq_ok;
            refresh_invalid <= seq_bad;
            refresh_busy <= seq_busy;
            wr_refused <= refused;
        end else begin
            // Pulses must not stretch while frozen
            refresh <= 1'b0;
            refresh_invalid <= 1'b0;
            wr_refused <= 1'b0;
        end
    end

endmodule : wdrl_top

`default_nettype wire

//--- test/wdrl_assertions.sv
/*
 * Port checker of the refresh sequencer and configuration lock.
 * Assumes binding to wdrl_top; ce drops only away from refresh traffic.
 */
`timescale 1ns/1ps
`default_nettype none
`include "wdrl_defines.svh"

module wdrl_assertions
    import wdrl_pkg::*;
#(
    parameter int REFRESH_SPAN = `WDRL_REFRESH_SPAN
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    input wire wdrl_wr_s wr,
    input wire wdrl_cfg_s cfg,
    input wire logic cfg_applied,
    input wire logic cfg_locked,
    input wire logic refresh,
    input wire logic refresh_invalid,
    input wire logic refresh_busy,
    input wire logic wr_refused
);
    // Write aimed at a configuration byte
    wire cfg_wr = wr.valid && ce && !(wr.target inside {WDRL_T_CNT_HI, WDRL_T_CNT_LO});
    // Last byte of a good refresh
    wire key_end = wr.valid && wr.target == WDRL_T_CNT_LO && wr.data == `WDRL_KEY2_LO;
    // Length of the current busy stretch; a hung sequencer grows it
    logic [7:0] busy_cnt;

    always_ff @(posedge clk_sys) begin
        if (!resetn || !refresh_busy) begin
            busy_cnt <= 8'h00;
        end else begin
            busy_cnt <= busy_cnt + 8'h01;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    chk_refresh_cause: assert property (refresh |-> $past(key_end, 2))
        else $error("refresh pulse without final key byte");
    chk_refresh_pulse: assert property (refresh |=> !refresh)
        else $error("refresh pulse longer than one cycle");
    chk_pulse_excl: assert property (!(refresh && refresh_invalid))
        else $error("refresh both good and invalid");
    chk_busy_bound: assert property (busy_cnt < REFRESH_SPAN)
        else $error("refresh sequence outlived its span");
    chk_apply_hold: assert property (cfg_applied |=> cfg_applied)
        else $error("applied setup dropped");
    chk_cfg_frozen: assert property (cfg_applied |=> $stable(cfg))
        else $error("setup changed after apply");
    chk_default_cfg: assert property (!cfg_applied |-> cfg == {`WDRL_CTL_ONE_RESET,
        `WDRL_CTL_TWO_RESET, `WDRL_TIMEOUT_RESET, `WDRL_WINDOW_RESET})
        else $error("defaults not in force before apply");
    chk_apply_cause: assert property ($rose(cfg_applied) |-> $past(cfg_wr))
        else $error("apply without a config write");
    chk_lock_cause: assert property (cfg_locked |-> cfg_applied &&
        !cfg.control_status_one[`WDRL_CTL_ONE_UPDATE_BIT])
        else $error("lock without update bit cleared");
    chk_lock_refuse: assert property (cfg_locked && cfg_wr |=> wr_refused)
        else $error("write while locked not refused");

    // Main scenarios reached
    cover property (refresh);
    cover property (refresh_invalid);
    cover property (cfg_locked && cfg_wr);
    cover property ($rose(cfg_applied) && cfg.control_status_two[`WDRL_CTL_TWO_WIN_BIT]);
endmodule : wdrl_assertions

bind wdrl_top wdrl_assertions #(.REFRESH_SPAN(REFRESH_SPAN)) wdrl_assertions_inst (
    .clk_sys(clk_sys), .resetn(resetn), .ce(ce), .wr(wr), .cfg(cfg),
    .cfg_applied(cfg_applied), .cfg_locked(cfg_locked), .refresh(refresh),
    .refresh_invalid(refresh_invalid), .refresh_busy(refresh_busy),
    .wr_refused(wr_refused)
);

`default_nettype wire

//--- test/tb.sv
/*
 * Self-checking bench of wdrl_top: refresh sequences and setup locking.
 * Assumes the defines header on the include path; drives on falling edges.
 */
`timescale 1ns/1ps
`default_nettype none
`include "wdrl_defines.svh"
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin err_total++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); end end

module tb
    import wdrl_pkg::*;
;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0; // Held low from time zero
    logic ce = 1'b1; // High except in one freeze step
    logic bz; // Busy level seen mid-sequence
    wdrl_wr_s wr = '0;
    wdrl_cfg_s cfg;
    logic cfg_applied, cfg_locked, refresh, refresh_invalid, refresh_busy, wr_refused;
    int err_total = 0;
    int checks_done = 0;
    int n_ok = 0, n_bad = 0, n_ref = 0; // Running pulse counts
    int s_ok, s_bad, s_ref; // Counts at scenario start
    localparam wdrl_cfg_s CFG_RST = {`WDRL_CTL_ONE_RESET, `WDRL_CTL_TWO_RESET,
        `WDRL_TIMEOUT_RESET, `WDRL_WINDOW_RESET};
    // Wrong refresh streams; last one is good data on the wrong byte
    localparam logic [31:0] BAD [5] = '{32'ha603b480, 32'ha602b481, 32'hb480a602,
        32'ha602a602, 32'ha602b480};

    always #10 clk_sys = ~clk_sys;

    // Pulses counted mid-cycle, so exact timing is left to the checker
    always @(negedge clk_sys) begin
        n_ok += int'(refresh === 1'b1);
        n_bad += int'(refresh_invalid === 1'b1);
        n_ref += int'(wr_refused === 1'b1);
    end

    wdrl_top #(.REFRESH_SPAN(16)) wdrl_top_inst (
        .clk_sys(clk_sys), .resetn(resetn), .ce(ce), .wr(wr), .cfg(cfg),
        .cfg_applied(cfg_applied), .cfg_locked(cfg_locked), .refresh(refresh),
        .refresh_invalid(refresh_invalid), .refresh_busy(refresh_busy),
        .wr_refused(wr_refused)
    );

    // One byte write, held over one rising edge
    task put(input wdrl_target_e t, input logic [7:0] d);
        @(negedge clk_sys);
        wr = '{valid: 1'b1, target: t, data: d};
    endtask : put

    task idle(input int n);
        repeat (n) begin
            @(negedge clk_sys);
            wr.valid = 1'b0;
        end
    endtask : idle

    task mark;
        s_ok = n_ok;
        s_bad = n_bad;
        s_ref = n_ref;
    endtask : mark

    task do_reset;
        @(negedge clk_sys);
        resetn = 1'b0;
        idle(2);
        resetn = 1'b1;
    endtask : do_reset

    // Four refresh bytes, a gap before the last, then time for any timeout
    task rseq(input logic [31:0] b, input wdrl_target_e t0, input int gap);
        mark;
        put(t0, b[31:24]);
        put(WDRL_T_CNT_LO, b[23:16]);
        put(WDRL_T_CNT_HI, b[15:8]);
        bz = refresh_busy; // Two bytes in: busy must show
        idle(gap);
        put(WDRL_T_CNT_LO, b[7:0]);
        idle(24);
    endtask : rseq

    task t_reset;
        `CHK("cfg", CFG_RST, cfg)
        `CHK("applied", 1'b0, cfg_applied)
    endtask : t_reset

    task t_refresh;
        // Back to back, then the last byte on span 15 and on span 16
        rseq(32'ha602b480, WDRL_T_CNT_HI, 0);
        `CHK("ok back to back", 1, n_ok - s_ok)
        `CHK("bad back to back", 0, n_bad - s_bad)
        `CHK("busy mid", 1'b1, bz)
        `CHK("busy idle", 1'b0, refresh_busy)
        rseq(32'ha602b480, WDRL_T_CNT_HI, 12);
        `CHK("ok span 15", 1, n_ok - s_ok)
        rseq(32'ha602b480, WDRL_T_CNT_HI, 13);
        `CHK("ok span 16", 0, n_ok - s_ok)
        `CHK("bad span 16", 1'b1, n_bad != s_bad)
        for (int i = 0; i < 5; i++) begin
            rseq(BAD[i], (i == 4) ? WDRL_T_CNT_LO : WDRL_T_CNT_HI, 0);
            `CHK("ok wrong order", 0, n_ok - s_ok)
            `CHK("bad wrong order", 1'b1, n_bad != s_bad)
        end
    endtask : t_refresh

    task t_cfg_nowin;
        // Timeout first, control last; window mode off
        do_reset;
        // Frozen: this write must leave no trace
        ce = 1'b0;
        put(WDRL_T_TOV_HI, 8'h99);
        idle(1);
        ce = 1'b1;
        put(WDRL_T_TOV_HI, 8'h12);
        put(WDRL_T_TOV_LO, 8'h34);
        put(WDRL_T_CTL_TWO, 8'h00);
        idle(2);
        `CHK("applied early", 1'b0, cfg_applied)
        put(WDRL_T_CTL_ONE, 8'h20);
        idle(2);
        `CHK("applied no window", 1'b1, cfg_applied)
        `CHK("cfg no window", 48'h2000_1234_0000, cfg)
        `CHK("locked update set", 1'b0, cfg_locked)
        mark;
        put(WDRL_T_TOV_HI, 8'h55);
        put(WDRL_T_CTL_ONE, 8'h00);
        idle(4);
        `CHK("refused rewrites", 2, n_ref - s_ref)
        `CHK("cfg after rewrite", 48'h2000_1234_0000, cfg)
    endtask : t_cfg_nowin

    task t_cfg_win;
        // Window mode on: apply waits for the window pair
        do_reset;
        put(WDRL_T_CTL_TWO, 8'h80);
        put(WDRL_T_TOV_HI, 8'h00);
        put(WDRL_T_TOV_LO, 8'h40);
        put(WDRL_T_CTL_ONE, 8'h00);
        idle(2);
        `CHK("applied no pair", 1'b0, cfg_applied)
        put(WDRL_T_WIN_HI, 8'h00);
        put(WDRL_T_WIN_LO, 8'h10);
        idle(2);
        `CHK("locked", 1'b1, cfg_locked)
        `CHK("cfg window", 48'h0080_0040_0010, cfg)
    endtask : t_cfg_win

    task t_cfg_skip;
        // Locked with window pair never written: pair stays blocked
        do_reset;
        put(WDRL_T_TOV_HI, 8'hff);
        put(WDRL_T_TOV_LO, 8'h00);
        put(WDRL_T_CTL_TWO, 8'h00);
        put(WDRL_T_CTL_ONE, 8'h00);
        idle(2);
        `CHK("locked skip", 1'b1, cfg_locked)
        mark;
        put(WDRL_T_WIN_HI, 8'h01);
        put(WDRL_T_WIN_LO, 8'h02);
        idle(4);
        `CHK("refused locked", 2, n_ref - s_ref)
        `CHK("cfg skip", 48'h0000_ff00_0000, cfg)
    endtask : t_cfg_skip

    task test_done;
        if (err_total == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done

    // Main sequence, reset held for two cycles
    initial begin
        idle(2);
        resetn = 1'b1;
        t_reset;
        t_refresh;
        t_cfg_nowin;
        t_cfg_win;
        t_cfg_skip;
        test_done;
    end

    // Tests need about 300 cycles; cut a hang off at 5000
    initial begin
        #100000;
        err_total++;
        test_done;
    end
endmodule : tb

`default_nettype wire
